// [logic/bscca_pkg.sv]
package bscca_pkg;
    // tap controller states, standard four-bit encoding
    typedef enum logic [3:0] {
        ST_RESET = 4'h0,
        ST_IDLE = 4'h1,
        ST_SEL_DR = 4'h2,
        ST_CAP_DR = 4'h3,
        ST_SH_DR = 4'h4,
        ST_EX1_DR = 4'h5,
        ST_PAU_DR = 4'h6,
        ST_EX2_DR = 4'h7,
        ST_UPD_DR = 4'h8,
        ST_SEL_IR = 4'h9,
        ST_CAP_IR = 4'ha,
        ST_SH_IR = 4'hb,
        ST_EX1_IR = 4'hc,
        ST_PAU_IR = 4'hd,
        ST_EX2_IR = 4'he,
        ST_UPD_IR = 4'hf
    } bscca_tap_t;
    localparam int IR_W = 4;
    localparam logic [3:0] OP_EXTEST = 4'h0;
    localparam logic [3:0] OP_SAMPLE = 4'h2;
    localparam logic [3:0] OP_BYPASS = 4'hf;
    localparam logic [3:0] IR_RESET = 4'hf;
    localparam logic [3:0] IR_CAPTURE = 4'h1;
    // chain layout, lsb nearest tdo
    localparam int CHAIN_W = 34;
    localparam int POS_EXT_EN = 0;
    localparam int POS_EXT_CK = 1;
    localparam int POS_OSC_EN = 2;
    localparam int POS_OSC_CK = 3;
    localparam int POS_LF_EN = 4;
    localparam int POS_LF_CK = 5;
    localparam int POS_AC_OFF = 6;
    localparam int POS_AC_RES = 7;
    localparam int POS_AC_MUX = 8;
    localparam int POS_AC_BG = 9;
    localparam int POS_CV_COMP = 10;
    localparam int POS_CV_ACLK = 11;
    localparam int POS_CV_ACT = 12;
    localparam int POS_CV_BG = 13;
    localparam int POS_CV_PWR = 14;
    localparam int POS_CV_AMP = 15;
    localparam int POS_CV_REF = 16;
    localparam int REF_W = 10;
    localparam int POS_CV_BYP = 26;
    localparam int POS_CV_GND = 27;
    localparam int POS_CV_SPARE = 28;
    localparam int SPARE_W = 6;
endpackage

// [logic/bscca_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module bscca_sync #(
    parameter int W = 1
) (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_r;
    logic [W-1:0] q_r;
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            // preload the pin level so no false edge follows reset
            meta_r <= d_i;
            q_r <= d_i;
        end
        else
        begin
            meta_r <= d_i;
            q_r <= meta_r;
        end
    end
    assign q_o = q_r;
endmodule
`default_nettype wire

// [logic/bscca_top.sv]
`timescale 1ns/1ps
`default_nettype none
module bscca_top (
    // system
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // test access port pins
    input wire logic tck_i,
    input wire logic tms_i,
    input wire logic tdi_i,
    input wire logic trst_i,
    output logic tdo_o,
    output logic tdo_oe_o,
    // functional side controls
    input wire logic external_clock_option_enable_i,
    input wire logic crystal_oscillator_enable_i,
    input wire logic low_freq_oscillator_enable_i,
    input wire logic comparator_power_off_i,
    input wire logic comparator_mux_select_i,
    input wire logic comparator_bandgap_select_i,
    input wire logic [5:0] converter_ctrl_i,
    input wire logic [9:0] converter_ref_i,
    input wire logic bypass_channel_connect_i,
    input wire logic converter_gnd_i,
    // analog side observed lines
    input wire logic external_clock_line_i,
    input wire logic crystal_oscillator_clock_i,
    input wire logic low_freq_oscillator_clock_i,
    input wire logic comparator_result_i,
    input wire logic converter_comp_i,
    // analog side controls
    output logic external_clock_option_enable_o,
    output logic crystal_oscillator_enable_o,
    output logic low_freq_oscillator_enable_o,
    output logic comparator_power_off_o,
    output logic comparator_mux_select_o,
    output logic comparator_bandgap_select_o,
    output logic converter_aclk_o,
    output logic converter_act_o,
    output logic converter_bg_o,
    output logic converter_power_on_o,
    output logic amplifier_power_on_o,
    output logic [9:0] converter_ref_o,
    output logic bypass_channel_connect_o,
    output logic converter_gnd_o,
    // observed values toward digital core
    output logic comparator_result_o,
    output logic converter_comp_o,
    output logic extest_active_o
);
    // ********************************
    // pin synchronisers
    // ********************************
    logic [8:0] pin_s;
    bscca_sync #(.W(9)) u_sync (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .d_i({converter_comp_i, comparator_result_i, low_freq_oscillator_clock_i,
              crystal_oscillator_clock_i, external_clock_line_i,
              trst_i, tdi_i, tms_i, tck_i}),
        .q_o(pin_s)
    );
    logic tck_s;
    logic tms_s;
    logic tdi_s;
    logic trst_s;
    assign tck_s = pin_s[0];
    assign tms_s = pin_s[1];
    assign tdi_s = pin_s[2];
    assign trst_s = pin_s[3];
    logic tck_d_r;
    logic tck_rise;
    logic tck_fall;
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
            tck_d_r <= tck_s;
        else
            tck_d_r <= tck_s;
    end
    assign tck_rise = tck_s & ~tck_d_r;
    assign tck_fall = ~tck_s & tck_d_r;
    // ********************************
    // tap controller
    // ********************************
    bscca_pkg::bscca_tap_t st_r;
    bscca_pkg::bscca_tap_t st_nxt;
    always_comb
    begin
        st_nxt = st_r;
        case (st_r)
            bscca_pkg::ST_RESET: st_nxt = tms_s ? bscca_pkg::ST_RESET : bscca_pkg::ST_IDLE;
            bscca_pkg::ST_IDLE: st_nxt = tms_s ? bscca_pkg::ST_SEL_DR : bscca_pkg::ST_IDLE;
            bscca_pkg::ST_SEL_DR: st_nxt = tms_s ? bscca_pkg::ST_SEL_IR : bscca_pkg::ST_CAP_DR;
            bscca_pkg::ST_CAP_DR: st_nxt = tms_s ? bscca_pkg::ST_EX1_DR : bscca_pkg::ST_SH_DR;
            bscca_pkg::ST_SH_DR: st_nxt = tms_s ? bscca_pkg::ST_EX1_DR : bscca_pkg::ST_SH_DR;
            bscca_pkg::ST_EX1_DR: st_nxt = tms_s ? bscca_pkg::ST_UPD_DR : bscca_pkg::ST_PAU_DR;
            bscca_pkg::ST_PAU_DR: st_nxt = tms_s ? bscca_pkg::ST_EX2_DR : bscca_pkg::ST_PAU_DR;
            bscca_pkg::ST_EX2_DR: st_nxt = tms_s ? bscca_pkg::ST_UPD_DR : bscca_pkg::ST_SH_DR;
            bscca_pkg::ST_UPD_DR: st_nxt = tms_s ? bscca_pkg::ST_SEL_DR : bscca_pkg::ST_IDLE;
            bscca_pkg::ST_SEL_IR: st_nxt = tms_s ? bscca_pkg::ST_RESET : bscca_pkg::ST_CAP_IR;
            bscca_pkg::ST_CAP_IR: st_nxt = tms_s ? bscca_pkg::ST_EX1_IR : bscca_pkg::ST_SH_IR;
            bscca_pkg::ST_SH_IR: st_nxt = tms_s ? bscca_pkg::ST_EX1_IR : bscca_pkg::ST_SH_IR;
            bscca_pkg::ST_EX1_IR: st_nxt = tms_s ? bscca_pkg::ST_UPD_IR : bscca_pkg::ST_PAU_IR;
            bscca_pkg::ST_PAU_IR: st_nxt = tms_s ? bscca_pkg::ST_EX2_IR : bscca_pkg::ST_PAU_IR;
            bscca_pkg::ST_EX2_IR: st_nxt = tms_s ? bscca_pkg::ST_UPD_IR : bscca_pkg::ST_SH_IR;
            bscca_pkg::ST_UPD_IR: st_nxt = tms_s ? bscca_pkg::ST_SEL_DR : bscca_pkg::ST_IDLE;
            default: st_nxt = bscca_pkg::ST_RESET;
        endcase
    end
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i || trst_s)
            st_r <= bscca_pkg::ST_RESET;
        else if (tck_rise)
            st_r <= st_nxt;
    end
    // ********************************
    // instruction register
    // ********************************
    logic [3:0] ir_sh_r;
    logic [3:0] ir_r;
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i || trst_s)
            ir_sh_r <= bscca_pkg::IR_CAPTURE;
        else if (tck_rise && st_r == bscca_pkg::ST_CAP_IR)
            ir_sh_r <= bscca_pkg::IR_CAPTURE;
        else if (tck_rise && st_r == bscca_pkg::ST_SH_IR)
            ir_sh_r <= {tdi_s, ir_sh_r[3:1]};
    end
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i || trst_s)
            ir_r <= bscca_pkg::IR_RESET;
        else if (st_r == bscca_pkg::ST_RESET)
            ir_r <= bscca_pkg::IR_RESET;
        else if (tck_fall && st_r == bscca_pkg::ST_UPD_IR)
            ir_r <= ir_sh_r;
    end
    logic sel_chain;
    logic extest;
    assign extest = (ir_r == bscca_pkg::OP_EXTEST);
    assign sel_chain = extest || (ir_r == bscca_pkg::OP_SAMPLE);
    // ********************************
    // boundary chain
    // ********************************
    logic [33:0] cap_v;
    logic [33:0] ch_r;
    logic [33:0] upd_r;
    logic byp_r;
    always_comb
    begin
        cap_v = '0;
        cap_v[bscca_pkg::POS_EXT_EN] = external_clock_option_enable_i;
        cap_v[bscca_pkg::POS_EXT_CK] = pin_s[4];
        cap_v[bscca_pkg::POS_OSC_EN] = crystal_oscillator_enable_i;
        cap_v[bscca_pkg::POS_OSC_CK] = pin_s[5];
        cap_v[bscca_pkg::POS_LF_EN] = low_freq_oscillator_enable_i;
        cap_v[bscca_pkg::POS_LF_CK] = pin_s[6];
        cap_v[bscca_pkg::POS_AC_OFF] = comparator_power_off_i;
        cap_v[bscca_pkg::POS_AC_RES] = pin_s[7];
        cap_v[bscca_pkg::POS_AC_MUX] = comparator_mux_select_i;
        cap_v[bscca_pkg::POS_AC_BG] = comparator_bandgap_select_i;
        cap_v[bscca_pkg::POS_CV_COMP] = pin_s[8];
        cap_v[bscca_pkg::POS_CV_ACLK +: 5] = converter_ctrl_i[4:0];
        cap_v[bscca_pkg::POS_CV_REF +: bscca_pkg::REF_W] = converter_ref_i;
        cap_v[bscca_pkg::POS_CV_BYP] = bypass_channel_connect_i;
        cap_v[bscca_pkg::POS_CV_GND] = converter_gnd_i;
        cap_v[bscca_pkg::POS_CV_SPARE] = converter_ctrl_i[5];
    end
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
            ch_r <= '0;
        else if (tck_rise && sel_chain && st_r == bscca_pkg::ST_CAP_DR)
            ch_r <= cap_v;
        else if (tck_rise && sel_chain && st_r == bscca_pkg::ST_SH_DR)
            ch_r <= {tdi_s, ch_r[33:1]};
    end
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
            upd_r <= '0;
        else if (tck_fall && sel_chain && st_r == bscca_pkg::ST_UPD_DR)
            upd_r <= ch_r;
    end
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
            byp_r <= 1'b0;
        else if (tck_rise && st_r == bscca_pkg::ST_CAP_DR)
            byp_r <= 1'b0;
        else if (tck_rise && st_r == bscca_pkg::ST_SH_DR)
            byp_r <= tdi_s;
    end
    // ********************************
    // tdo on falling test clock
    // ********************************
    logic tdo_r;
    logic tdo_oe_r;
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            tdo_r <= 1'b0;
            tdo_oe_r <= 1'b0;
        end
        else if (tck_fall)
        begin
            tdo_oe_r <= (st_r == bscca_pkg::ST_SH_DR) || (st_r == bscca_pkg::ST_SH_IR);
            if (st_r == bscca_pkg::ST_SH_IR)
                tdo_r <= ir_sh_r[0];
            else if (sel_chain)
                tdo_r <= ch_r[0];
            else
                tdo_r <= byp_r;
        end
    end
    assign tdo_o = tdo_r;
    assign tdo_oe_o = tdo_oe_r;
    // ********************************
    // analog side drive
    // ********************************
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            external_clock_option_enable_o <= 1'b0;
            crystal_oscillator_enable_o <= 1'b0;
            low_freq_oscillator_enable_o <= 1'b0;
            comparator_power_off_o <= 1'b0;
            comparator_mux_select_o <= 1'b0;
            comparator_bandgap_select_o <= 1'b0;
            converter_aclk_o <= 1'b0;
            converter_act_o <= 1'b0;
            converter_bg_o <= 1'b0;
            converter_power_on_o <= 1'b0;
            amplifier_power_on_o <= 1'b0;
            converter_ref_o <= '0;
            bypass_channel_connect_o <= 1'b0;
            converter_gnd_o <= 1'b0;
            comparator_result_o <= 1'b0;
            converter_comp_o <= 1'b0;
        end
        else
        begin
            external_clock_option_enable_o <= extest ? upd_r[bscca_pkg::POS_EXT_EN]
                : external_clock_option_enable_i;
            crystal_oscillator_enable_o <= extest ? upd_r[bscca_pkg::POS_OSC_EN]
                : crystal_oscillator_enable_i;
            low_freq_oscillator_enable_o <= extest ? upd_r[bscca_pkg::POS_LF_EN]
                : low_freq_oscillator_enable_i;
            comparator_power_off_o <= extest ? upd_r[bscca_pkg::POS_AC_OFF]
                : comparator_power_off_i;
            comparator_mux_select_o <= extest ? upd_r[bscca_pkg::POS_AC_MUX]
                : comparator_mux_select_i;
            comparator_bandgap_select_o <= extest ? upd_r[bscca_pkg::POS_AC_BG]
                : comparator_bandgap_select_i;
            converter_aclk_o <= extest ? upd_r[bscca_pkg::POS_CV_ACLK] : converter_ctrl_i[0];
            converter_act_o <= extest ? upd_r[bscca_pkg::POS_CV_ACT] : converter_ctrl_i[1];
            converter_bg_o <= extest ? upd_r[bscca_pkg::POS_CV_BG] : converter_ctrl_i[2];
            converter_power_on_o <= extest ? upd_r[bscca_pkg::POS_CV_PWR]
                : converter_ctrl_i[3];
            amplifier_power_on_o <= extest ? upd_r[bscca_pkg::POS_CV_AMP]
                : converter_ctrl_i[4];
            converter_ref_o <= extest ? upd_r[bscca_pkg::POS_CV_REF +: bscca_pkg::REF_W]
                : converter_ref_i;
            bypass_channel_connect_o <= extest ? upd_r[bscca_pkg::POS_CV_BYP]
                : bypass_channel_connect_i;
            converter_gnd_o <= extest ? upd_r[bscca_pkg::POS_CV_GND] : converter_gnd_i;
            comparator_result_o <= extest ? upd_r[bscca_pkg::POS_AC_RES] : pin_s[7];
            converter_comp_o <= extest ? upd_r[bscca_pkg::POS_CV_COMP] : pin_s[8];
        end
    end
    assign extest_active_o = extest;
endmodule
`default_nettype wire

// [dv/bscca_top_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module bscca_top_asserts (
    // system
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // test pins
    input wire logic tck_i,
    input wire logic trst_i,
    input wire logic tdo_o,
    input wire logic tdo_oe_o,
    // functional inputs
    input wire logic external_clock_option_enable_i,
    input wire logic low_freq_oscillator_enable_i,
    input wire logic comparator_power_off_i,
    input wire logic [5:0] converter_ctrl_i,
    input wire logic [9:0] converter_ref_i,
    input wire logic bypass_channel_connect_i,
    // analog side and status
    input wire logic external_clock_option_enable_o,
    input wire logic low_freq_oscillator_enable_o,
    input wire logic comparator_power_off_o,
    input wire logic converter_power_on_o,
    input wire logic amplifier_power_on_o,
    input wire logic [9:0] converter_ref_o,
    input wire logic bypass_channel_connect_o,
    input wire logic comparator_result_o,
    input wire logic extest_active_o
);
    // ****
    // pass-through and hold checks
    // ****
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (reset_i);
    sequence s_follow;
        !$past(reset_i) && !$past(extest_active_o);
    endsequence
    sequence s_quiet;
        $stable({tck_i, trst_i})[*8];
    endsequence
    property p_ext;
        s_follow |-> external_clock_option_enable_o == $past(external_clock_option_enable_i);
    endproperty
    a_ext: assert property (p_ext) else $error("clock enable not passed");
    property p_lf;
        s_follow |-> low_freq_oscillator_enable_o == $past(low_freq_oscillator_enable_i);
    endproperty
    a_lf: assert property (p_lf) else $error("low freq enable not passed");
    property p_ac;
        s_follow |-> comparator_power_off_o == $past(comparator_power_off_i);
    endproperty
    a_ac: assert property (p_ac) else $error("comparator control not passed");
    property p_cv;
        s_follow |-> {amplifier_power_on_o, converter_power_on_o} == $past(converter_ctrl_i[4:3]);
    endproperty
    a_cv: assert property (p_cv) else $error("converter power not passed");
    property p_ref;
        s_follow |-> converter_ref_o == $past(converter_ref_i);
    endproperty
    a_ref: assert property (p_ref) else $error("reference word not passed");
    property p_byp;
        s_follow |-> bypass_channel_connect_o == $past(bypass_channel_connect_i);
    endproperty
    a_byp: assert property (p_byp) else $error("bypass connect not passed");
    property p_hold;
        s_quiet ##0 extest_active_o |-> $stable({external_clock_option_enable_o,
            low_freq_oscillator_enable_o, comparator_power_off_o, converter_power_on_o,
            amplifier_power_on_o, converter_ref_o, bypass_channel_connect_o,
            comparator_result_o});
    endproperty
    a_hold: assert property (p_hold) else $error("driven cell moved without test clock");
    property p_tap;
        s_quiet |-> $stable({tdo_o, tdo_oe_o, extest_active_o});
    endproperty
    a_tap: assert property (p_tap) else $error("test port moved without test clock");
endmodule
`default_nettype wire

// [dv/bscca_tester.sv]
`timescale 1ns/1ps
`default_nettype none
module bscca_tester (
    // system
    input wire logic sys_clk_i,
    // test pins
    input wire logic tdo_i,
    input wire logic tdo_oe_i,
    output logic tck_o,
    output logic tms_o,
    output logic tdi_o
);
    // ****
    // tap stepping, clock parked high between steps
    // ****
    int oe_hits;
    initial
    begin
        tck_o = 1'b1;
        tms_o = 1'b1;
        tdi_o = 1'b0;
    end
    task automatic step(input logic m, input logic d, output logic q);
        @(posedge sys_clk_i);
        tck_o <= 1'b0;
        tms_o <= m;
        tdi_o <= d;
        repeat (20) @(posedge sys_clk_i);
        q = tdo_i;
        if (tdo_oe_i)
            oe_hits++;
        tck_o <= 1'b1;
        repeat (20) @(posedge sys_clk_i);
    endtask
    task automatic reset_tap();
        logic b;
        repeat (5) step(1'b1, ~tdi_o, b);
        step(1'b0, ~tdi_o, b);
    endtask
    // ir or dr scan from idle back to idle
    task automatic scan(input logic ir, input int n, input logic [33:0] d,
        output logic [33:0] q);
        logic b;
        q = '0;
        oe_hits = 0;
        step(1'b1, ~tdi_o, b);
        if (ir)
            step(1'b1, ~tdi_o, b);
        step(1'b0, ~tdi_o, b);
        step(1'b0, ~tdi_o, b);
        for (int i = 0; i < n; i++)
        begin
            step(i == n - 1, d[i], b);
            q[i] = b;
        end
        step(1'b1, ~tdi_o, b);
        step(1'b0, ~tdi_o, b);
    endtask
endmodule
`default_nettype wire

// [dv/test_boundary_scan_clock_analog_cells.sv]
`timescale 1ns/1ps
`default_nettype none
module test_boundary_scan_clock_analog_cells;
    // ****
    // bench
    // ****
    localparam logic [33:0] MASK = 34'h0fffffd5;
    localparam logic [33:0] V1 = 34'h13a5e6c9;
    localparam logic [33:0] V2 = 34'h0e1b372b;
    localparam logic [33:0] P = 34'h0bd24ac4;
    localparam logic [33:0] U = 34'h06000041;
    localparam logic [33:0] D = 34'h3a5c39e71;
    logic sys_clk_i;
    logic reset_i;
    logic trst;
    logic tck, tms, tdi, tdo, oe, ext;
    logic [33:0] fv;
    logic [33:0] q;
    wire logic [33:0] ov;
    assign ov[1] = 1'b0;
    assign ov[3] = 1'b0;
    assign ov[5] = 1'b0;
    assign ov[33:28] = '0;
    int n_fail;
    int compares;
    bscca_top dut (
        .sys_clk_i(sys_clk_i), .reset_i(reset_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
        .trst_i(trst), .tdo_o(tdo), .tdo_oe_o(oe),
        .external_clock_option_enable_i(fv[0]), .crystal_oscillator_enable_i(fv[2]),
        .low_freq_oscillator_enable_i(fv[4]), .comparator_power_off_i(fv[6]),
        .comparator_mux_select_i(fv[8]), .comparator_bandgap_select_i(fv[9]),
        .converter_ctrl_i({fv[28], fv[15:11]}), .converter_ref_i(fv[25:16]),
        .bypass_channel_connect_i(fv[26]), .converter_gnd_i(fv[27]),
        .external_clock_line_i(fv[1]), .crystal_oscillator_clock_i(fv[3]),
        .low_freq_oscillator_clock_i(fv[5]), .comparator_result_i(fv[7]),
        .converter_comp_i(fv[10]),
        .external_clock_option_enable_o(ov[0]), .crystal_oscillator_enable_o(ov[2]),
        .low_freq_oscillator_enable_o(ov[4]), .comparator_power_off_o(ov[6]),
        .comparator_mux_select_o(ov[8]), .comparator_bandgap_select_o(ov[9]),
        .converter_aclk_o(ov[11]), .converter_act_o(ov[12]), .converter_bg_o(ov[13]),
        .converter_power_on_o(ov[14]), .amplifier_power_on_o(ov[15]),
        .converter_ref_o(ov[25:16]), .bypass_channel_connect_o(ov[26]),
        .converter_gnd_o(ov[27]), .comparator_result_o(ov[7]), .converter_comp_o(ov[10]),
        .extest_active_o(ext)
    );
    bscca_tester tst (.sys_clk_i(sys_clk_i), .tdo_i(tdo), .tdo_oe_i(oe), .tck_o(tck),
        .tms_o(tms), .tdi_o(tdi));
    initial
    begin
        sys_clk_i = 1'b0;
        forever #2 sys_clk_i = ~sys_clk_i;
    end
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic put(input logic [33:0] v);
        @(posedge sys_clk_i);
        fv <= v;
        repeat (8) @(posedge sys_clk_i);
    endtask
    task automatic finish_test();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // ****
    // tests
    // ****
    initial
    begin
        n_fail = 0;
        compares = 0;
        fv = '0;
        trst = 1'b0;
        reset_i = 1'b1;
        repeat (16) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        repeat (4) @(posedge sys_clk_i);
        put(V1);
        chk(ov & MASK, V1 & MASK);
        tst.reset_tap();
        tst.scan(1'b1, 4, 34'h2, q);
        chk(q, 34'h1);
        tst.scan(1'b0, 34, P, q);
        chk(q, V1);
        chk(34'(tst.oe_hits), 34'd34);
        chk(ov & MASK, V1 & MASK);
        tst.scan(1'b1, 4, 34'h0, q);
        chk({33'h0, ext}, 34'h1);
        chk(ov & MASK, P & MASK);
        put(V2);
        chk(ov & MASK, P & MASK);
        tst.scan(1'b0, 34, U, q);
        chk(q, V2);
        chk(ov & MASK, U & MASK);
        tst.scan(1'b1, 4, 34'hf, q);
        chk(q, 34'h1);
        chk(ov & MASK, V2 & MASK);
        tst.scan(1'b0, 34, D, q);
        chk(q, {D[32:0], 1'b0});
        tst.scan(1'b1, 4, 34'h0, q);
        chk({33'h0, ext}, 34'h1);
        chk(ov & MASK, U & MASK);
        @(posedge sys_clk_i);
        trst <= 1'b1;
        repeat (8) @(posedge sys_clk_i);
        trst <= 1'b0;
        repeat (8) @(posedge sys_clk_i);
        chk({33'h0, ext}, 34'h0);
        chk(ov & MASK, V2 & MASK);
        finish_test();
    end
    initial
    begin
        repeat (30000) @(posedge sys_clk_i);
        n_fail++;
        finish_test();
    end
endmodule
bind bscca_top bscca_top_asserts u_chk (
    .sys_clk_i, .reset_i, .tck_i, .trst_i, .tdo_o, .tdo_oe_o,
    .external_clock_option_enable_i, .low_freq_oscillator_enable_i,
    .comparator_power_off_i, .converter_ctrl_i, .converter_ref_i,
    .bypass_channel_connect_i, .external_clock_option_enable_o,
    .low_freq_oscillator_enable_o, .comparator_power_off_o, .converter_power_on_o,
    .amplifier_power_on_o, .converter_ref_o, .bypass_channel_connect_o,
    .comparator_result_o, .extest_active_o
);
`default_nettype wire
